/* pkg/boot_gpio_pkg.sv */
// Constants for the boot, pin multiplexer and status register bank
package boot_gpio_pkg;
  // Clock and serial memory timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_NS_0 = 800;
  localparam int SCLK_NS_1 = 400;
  localparam int SCLK_NS_2 = 200;
  localparam int SCLK_NS_3 = 100;
  localparam logic [3:0] HALF_CYC_0 = 4'((SCLK_NS_0 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HALF_CYC_1 = 4'((SCLK_NS_1 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HALF_CYC_2 = 4'((SCLK_NS_2 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HALF_CYC_3 = 4'((SCLK_NS_3 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MEM_CTRL = 8'h56;
  localparam logic [7:0] IDX_RD_OPCODE = 8'h57;
  localparam logic [7:0] IDX_ADDR_HIGH = 8'h58;
  localparam logic [7:0] IDX_ADDR_MID = 8'h59;
  localparam logic [7:0] IDX_ADDR_LOW = 8'h5a;
  localparam logic [7:0] IDX_BOOT_STATUS = 8'h5b;
  localparam logic [7:0] IDX_BQ_MARKER = 8'h5c;
  localparam logic [7:0] IDX_SUPPLY = 8'h5e;
  localparam logic [7:0] IDX_PIN_DIR = 8'h60;
  localparam logic [7:0] IDX_PIN0_FN = 8'h61;
  localparam logic [7:0] IDX_PIN1_FN = 8'h62;
  localparam logic [7:0] IDX_PIN2_FN = 8'h63;
  localparam logic [7:0] IDX_IN_ROUTE = 8'h64;
  localparam logic [7:0] IDX_OUT_LEVEL = 8'h65;
  localparam logic [7:0] IDX_OUT_INV = 8'h66;
  localparam logic [7:0] IDX_SILICON_ID = 8'h67;
  localparam logic [7:0] IDX_OP_STATE = 8'h68;
  localparam logic [7:0] IDX_MUTE_STAT = 8'h69;
  localparam logic [7:0] IDX_RAMP_PHASE = 8'h6a;
  // Reset values
  localparam logic [7:0] RST_RD_OPCODE = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Memory control field positions
  localparam int MC_SOURCE = 0;
  localparam int MC_LSB_FIRST = 1;
  localparam int MC_CLK_EDGE = 2;
  localparam int MC_RATE_LO = 3;
  localparam int MC_WIDE_ADDR = 5;
  // Boot status field positions
  localparam int BS_DONE = 0;
  localparam int BS_CRC_ERR = 1;
  // Input routing and ramp phase field positions
  localparam int RT_MUTE_LO = 0;
  localparam int RT_RESET_LO = 2;
  localparam int RT_SYNC_LO = 4;
  localparam int RT_SERIAL_LO = 6;
  localparam int PH_LO = 2;
  // Operating state codes
  localparam logic [1:0] OP_PLAY = 2'h3;
  // Pin function codes
  typedef enum logic [3:0] {
    FN_OFF = 4'h0, FN_TWO_LEVEL = 4'h1, FN_REG = 4'h2, FN_BOTH_MUTE = 4'h3,
    FN_LEFT_MUTE = 4'h4, FN_RIGHT_MUTE = 4'h5, FN_CLK_INVALID = 4'h6, FN_WARN = 4'h8,
    FN_MULTI_LEVEL = 4'h9, FN_FAULT = 4'hb, FN_MEM_CLK = 4'hc, FN_MEM_DOUT = 4'hd
  } pin_fn_t;
  localparam logic [7:0] CRC_POLY = 8'h07;
endpackage : boot_gpio_pkg

/* src/boot_gpio_mux_status_regs.sv */
// Register bank with serial memory boot loader and pin multiplexer
`timescale 1ns/1ps
module boot_gpio_mux_status_regs #(
  parameter int BOOT_BYTES = 16,
  parameter logic [7:0] SILICON_ID = 8'h5a // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [2:0] pin_i,
  output logic [2:0] pin_o,
  output logic [2:0] pin_oe_o,
  input wire logic memory_din_i,
  output logic memory_clk_o,
  output logic memory_dout_o,
  output logic memory_select_n_o,
  output logic [7:0] coef_byte_o,
  output logic coef_valid_o,
  output logic coef_from_memory_o,
  output logic biquad_first_word_o,
  input wire logic [7:0] stage_supply_code_i,
  input wire logic [1:0] op_state_code_i,
  input wire logic left_muted_flag_i,
  input wire logic right_muted_flag_i,
  input wire logic clock_invalid_i,
  input wire logic warning_out_n_i,
  input wire logic fault_out_n_i,
  input wire logic two_level_wave_i,
  input wire logic multi_level_wave_i,
  output logic hiz_request_o,
  output logic pin_reset_o,
  output logic phase_sync_o,
  output logic [1:0] ramp_phase_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_READ} boot_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and input routing
  logic [3:0] in_meta_r;
  logic [3:0] in_sync_r;
  logic [7:0] route_r;
  logic pin_reset_act;
  logic soft_rst;
  logic serial_in;

  always_ff @(posedge clk_i) begin
    in_meta_r <= {memory_din_i, pin_i};
    in_sync_r <= in_meta_r;
  end

  function automatic logic route_pick(input logic [1:0] sel, input logic [3:0] src, input logic dflt);
    route_pick = (sel == 2'b00) ? dflt : src[sel - 2'd1];
  endfunction : route_pick

  localparam int RTR = boot_gpio_pkg::RT_RESET_LO;
  assign pin_reset_act = route_pick(route_r[RTR+1:RTR], in_sync_r, 1'b1) == 1'b0;
  assign soft_rst = reset_i | pin_reset_act;
  assign pin_reset_o = pin_reset_act;
  assign serial_in = route_pick(route_r[boot_gpio_pkg::RT_SERIAL_LO+1:boot_gpio_pkg::RT_SERIAL_LO],
                                in_sync_r, in_sync_r[3]);
  assign phase_sync_o = route_pick(route_r[boot_gpio_pkg::RT_SYNC_LO+1:boot_gpio_pkg::RT_SYNC_LO],
                                   in_sync_r, 1'b0);
  assign hiz_request_o = !route_pick(route_r[boot_gpio_pkg::RT_MUTE_LO+1:boot_gpio_pkg::RT_MUTE_LO],
                                     in_sync_r, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic addr_ok;
  logic [7:0] a_idx;
  logic [7:0] rd_val;
  logic [7:0] wdat;

  assign a_idx = haddr_i[9:2];
  assign addr_ok = hsel_i && hready_i && htrans_i[1] && (haddr_i[31:10] == 22'h0);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wdat = hwdata_i[7:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_o <= 32'h0;
    end else begin
      wr_pend_r <= addr_ok && hwrite_i;
      wr_idx_r <= a_idx;
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= {24'h0, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] mem_ctrl_r;
  logic [7:0] opcode_r;
  logic [7:0] addr_hi_r;
  logic [7:0] addr_mid_r;
  logic [7:0] addr_lo_r;
  logic bq_mark_r;
  logic [2:0] dir_r;
  logic [3:0] fn_r [3];
  logic [7:0] route_keep_r;
  logic [2:0] out_lvl_r;
  logic [2:0] out_inv_r;
  logic [1:0] phase_r;
  logic start_pulse;
  logic [1:0] rst_route_r;

  function automatic logic wr_hit(input logic [7:0] idx, input logic pend, input logic [7:0] widx);
    wr_hit = pend && (widx == idx);
  endfunction : wr_hit

  assign start_pulse = wr_hit(boot_gpio_pkg::IDX_MEM_CTRL, wr_pend_r, wr_idx_r) && !soft_rst
                       && wdat[boot_gpio_pkg::MC_SOURCE] && !mem_ctrl_r[boot_gpio_pkg::MC_SOURCE];

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      mem_ctrl_r <= boot_gpio_pkg::RST_ZERO;
      opcode_r <= boot_gpio_pkg::RST_RD_OPCODE;
      addr_hi_r <= boot_gpio_pkg::RST_ZERO;
      addr_mid_r <= boot_gpio_pkg::RST_ZERO;
      addr_lo_r <= boot_gpio_pkg::RST_ZERO;
      bq_mark_r <= 1'b0;
      dir_r <= 3'h0;
      route_keep_r <= boot_gpio_pkg::RST_ZERO;
      out_lvl_r <= 3'h0;
      out_inv_r <= 3'h0;
      phase_r <= 2'h0;
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        boot_gpio_pkg::IDX_MEM_CTRL: mem_ctrl_r <= {2'b00, wdat[5:0]};
        boot_gpio_pkg::IDX_RD_OPCODE: opcode_r <= wdat;
        boot_gpio_pkg::IDX_ADDR_HIGH: addr_hi_r <= wdat;
        boot_gpio_pkg::IDX_ADDR_MID: addr_mid_r <= wdat;
        boot_gpio_pkg::IDX_ADDR_LOW: addr_lo_r <= wdat;
        boot_gpio_pkg::IDX_BQ_MARKER: bq_mark_r <= wdat[0];
        boot_gpio_pkg::IDX_PIN_DIR: dir_r <= wdat[2:0];
        boot_gpio_pkg::IDX_IN_ROUTE: route_keep_r <= wdat;
        boot_gpio_pkg::IDX_OUT_LEVEL: out_lvl_r <= wdat[2:0];
        boot_gpio_pkg::IDX_OUT_INV: out_inv_r <= wdat[2:0];
        boot_gpio_pkg::IDX_RAMP_PHASE: phase_r <= wdat[boot_gpio_pkg::PH_LO+1:boot_gpio_pkg::PH_LO];
        default: ;
      endcase
    end
  end

  // Reset routing field survives a reset from its own pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rst_route_r <= 2'b00;
    end else if (wr_hit(boot_gpio_pkg::IDX_IN_ROUTE, wr_pend_r, wr_idx_r) && !pin_reset_act) begin
      rst_route_r <= wdat[RTR+1:RTR];
    end
  end

  always_comb begin
    route_r = route_keep_r;
    route_r[RTR+1:RTR] = rst_route_r;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_fn
      always_ff @(posedge clk_i) begin
        if (soft_rst) begin
          fn_r[g] <= 4'h0;
        end else if (wr_hit(boot_gpio_pkg::IDX_PIN0_FN + 8'(g), wr_pend_r, wr_idx_r)) begin
          fn_r[g] <= wdat[3:0];
        end
      end
    end
  endgenerate

  assign coef_from_memory_o = mem_ctrl_r[boot_gpio_pkg::MC_SOURCE];
  assign biquad_first_word_o = bq_mark_r;

  // Phase only follows the register outside play
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ramp_phase_o <= 2'h0;
    end else if (op_state_code_i != boot_gpio_pkg::OP_PLAY) begin
      ramp_phase_o <= phase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial memory boot engine
  boot_state_t st_r;
  logic [3:0] hc_r;
  logic half_r;
  logic [2:0] bit_r;
  logic [7:0] cnt_r;
  logic [31:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] crc_r;
  logic done_r;
  logic crc_err_r;
  logic [3:0] half_lim;
  logic tick;
  logic pol;
  logic lsb;
  logic [31:0] tx_load;
  logic [31:0] tx_next;
  logic byte_end;

  assign pol = mem_ctrl_r[boot_gpio_pkg::MC_CLK_EDGE];
  assign lsb = mem_ctrl_r[boot_gpio_pkg::MC_LSB_FIRST];
  assign tx_load = mem_ctrl_r[boot_gpio_pkg::MC_WIDE_ADDR] ? {opcode_r, addr_hi_r, addr_mid_r, addr_lo_r}
                                                           : {opcode_r, addr_mid_r, addr_lo_r, 8'h00};
  assign tick = (hc_r == half_lim);
  assign byte_end = tick && half_r && (bit_r == 3'd7);
  assign tx_next = (byte_end && st_r == ST_SEND) ? {tx_r[23:0], 8'h00} : tx_r;

  always_comb begin
    case (mem_ctrl_r[boot_gpio_pkg::MC_RATE_LO+1:boot_gpio_pkg::MC_RATE_LO])
      2'd0: half_lim = boot_gpio_pkg::HALF_CYC_0 - 4'd1;
      2'd1: half_lim = boot_gpio_pkg::HALF_CYC_1 - 4'd1;
      2'd2: half_lim = boot_gpio_pkg::HALF_CYC_2 - 4'd1;
      default: half_lim = boot_gpio_pkg::HALF_CYC_3 - 4'd1;
    endcase
  end

  function automatic logic out_bit(input logic [31:0] tx, input logic [2:0] k, input logic lsb_first);
    out_bit = lsb_first ? tx[24 + 32'(k)] : tx[31 - 32'(k)];
  endfunction : out_bit

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ boot_gpio_pkg::CRC_POLY) : (r << 1);
    end
    crc8 = r;
  endfunction : crc8

  always_ff @(posedge clk_i) begin
    coef_valid_o <= 1'b0;
    if (soft_rst) begin
      st_r <= ST_IDLE;
      hc_r <= 4'h0;
      half_r <= 1'b0;
      bit_r <= 3'h0;
      cnt_r <= 8'h00;
      tx_r <= 32'h0;
      rx_r <= 8'h00;
      crc_r <= 8'h00;
      done_r <= 1'b0;
      crc_err_r <= 1'b0;
      memory_clk_o <= 1'b0;
      memory_dout_o <= 1'b0;
      memory_select_n_o <= 1'b1;
      coef_byte_o <= 8'h00;
    end else begin
      case (st_r)
        ST_IDLE: begin
          memory_clk_o <= pol;
          if (start_pulse) begin
            st_r <= ST_SEND;
            done_r <= 1'b0;
            crc_err_r <= 1'b0;
            crc_r <= 8'h00;
            tx_r <= tx_load;
            cnt_r <= mem_ctrl_r[boot_gpio_pkg::MC_WIDE_ADDR] ? 8'd4 : 8'd3;
            hc_r <= 4'h0;
            half_r <= 1'b0;
            bit_r <= 3'h0;
            memory_select_n_o <= 1'b0;
            memory_clk_o <= ~pol;
            memory_dout_o <= out_bit(tx_load, 3'h0, lsb);
          end
        end
        ST_SEND, ST_READ: begin
          hc_r <= tick ? 4'h0 : hc_r + 4'd1;
          if (tick && !half_r) begin
            half_r <= 1'b1;
            memory_clk_o <= pol;
            if (st_r == ST_READ) begin
              rx_r <= lsb ? {serial_in, rx_r[7:1]} : {rx_r[6:0], serial_in};
            end
          end else if (tick) begin
            half_r <= 1'b0;
            bit_r <= bit_r + 3'd1;
            tx_r <= tx_next;
            memory_clk_o <= ~pol;
            memory_dout_o <= out_bit(tx_next, bit_r + 3'd1, lsb);
            if (byte_end && st_r == ST_SEND) begin
              cnt_r <= cnt_r - 8'd1;
              if (cnt_r == 8'd1) begin
                st_r <= ST_READ;
                cnt_r <= 8'(BOOT_BYTES + 1);
              end
            end else if (byte_end) begin
              cnt_r <= cnt_r - 8'd1;
              if (cnt_r == 8'd1) begin
                st_r <= ST_IDLE;
                done_r <= 1'b1;
                crc_err_r <= (rx_r != crc_r);
                memory_select_n_o <= 1'b1;
                memory_clk_o <= pol;
              end else begin
                crc_r <= crc8(crc_r, rx_r);
                coef_byte_o <= rx_r;
                coef_valid_o <= 1'b1;
              end
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin output multiplexer
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      logic lvl;
      always_comb begin
        case (fn_r[g])
          boot_gpio_pkg::FN_TWO_LEVEL: lvl = two_level_wave_i;
          boot_gpio_pkg::FN_REG: lvl = out_lvl_r[g];
          boot_gpio_pkg::FN_BOTH_MUTE: lvl = left_muted_flag_i & right_muted_flag_i;
          boot_gpio_pkg::FN_LEFT_MUTE: lvl = left_muted_flag_i;
          boot_gpio_pkg::FN_RIGHT_MUTE: lvl = right_muted_flag_i;
          boot_gpio_pkg::FN_CLK_INVALID: lvl = clock_invalid_i;
          boot_gpio_pkg::FN_WARN: lvl = warning_out_n_i;
          boot_gpio_pkg::FN_MULTI_LEVEL: lvl = multi_level_wave_i;
          boot_gpio_pkg::FN_FAULT: lvl = fault_out_n_i;
          boot_gpio_pkg::FN_MEM_CLK: lvl = memory_clk_o;
          boot_gpio_pkg::FN_MEM_DOUT: lvl = memory_dout_o;
          default: lvl = 1'b0;
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (soft_rst) begin
          pin_o[g] <= 1'b0;
        end else begin
          pin_o[g] <= lvl ^ out_inv_r[g];
        end
      end
    end
  endgenerate

  assign pin_oe_o = dir_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    case (a_idx)
      boot_gpio_pkg::IDX_MEM_CTRL: rd_val = mem_ctrl_r;
      boot_gpio_pkg::IDX_RD_OPCODE: rd_val = opcode_r;
      boot_gpio_pkg::IDX_ADDR_HIGH: rd_val = addr_hi_r;
      boot_gpio_pkg::IDX_ADDR_MID: rd_val = addr_mid_r;
      boot_gpio_pkg::IDX_ADDR_LOW: rd_val = addr_lo_r;
      boot_gpio_pkg::IDX_BOOT_STATUS: rd_val = {6'h0, crc_err_r, done_r};
      boot_gpio_pkg::IDX_BQ_MARKER: rd_val = {7'h0, bq_mark_r};
      boot_gpio_pkg::IDX_SUPPLY: rd_val = stage_supply_code_i;
      boot_gpio_pkg::IDX_PIN_DIR: rd_val = {5'h0, dir_r};
      boot_gpio_pkg::IDX_PIN0_FN: rd_val = {4'h0, fn_r[0]};
      boot_gpio_pkg::IDX_PIN1_FN: rd_val = {4'h0, fn_r[1]};
      boot_gpio_pkg::IDX_PIN2_FN: rd_val = {4'h0, fn_r[2]};
      boot_gpio_pkg::IDX_IN_ROUTE: rd_val = route_r;
      boot_gpio_pkg::IDX_OUT_LEVEL: rd_val = {5'h0, out_lvl_r};
      boot_gpio_pkg::IDX_OUT_INV: rd_val = {5'h0, out_inv_r};
      boot_gpio_pkg::IDX_SILICON_ID: rd_val = SILICON_ID;
      boot_gpio_pkg::IDX_OP_STATE: rd_val = {6'h0, op_state_code_i};
      boot_gpio_pkg::IDX_MUTE_STAT: rd_val = {6'h0, right_muted_flag_i, left_muted_flag_i};
      boot_gpio_pkg::IDX_RAMP_PHASE: rd_val = {4'h0, phase_r, 2'b00};
      default: rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_opcode_reset: assert property (@(posedge clk_i) $fell(reset_i) |-> opcode_r == boot_gpio_pkg::RST_RD_OPCODE)
    else $error("read opcode not 03h after reset");
  a_pin_direction: assert property (@(posedge clk_i) disable iff (soft_rst)
    wr_hit(boot_gpio_pkg::IDX_PIN_DIR, wr_pend_r, wr_idx_r) |=> pin_oe_o == $past(wdat[2:0]))
    else $error("pin enable differs from written direction bits");
  a_mute_hiz: assert property (@(posedge clk_i) disable iff (reset_i)
    (route_r[1:0] == 2'b01 && !in_sync_r[0]) |-> hiz_request_o)
    else $error("routed mute did not request high impedance");
  a_route_survives: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_reset_act |=> rst_route_r == $past(rst_route_r))
    else $error("reset routing lost on pin reset");
  a_done_after_read: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(done_r) |-> $past(st_r) == ST_READ && memory_select_n_o)
    else $error("done flag rose outside read phase");
  a_start_selects: assert property (@(posedge clk_i) disable iff (soft_rst)
    start_pulse && st_r == ST_IDLE |=> !memory_select_n_o && st_r == ST_SEND ##1 !memory_select_n_o)
    else $error("boot start did not open a frame");
  a_off_pin_low: assert property (@(posedge clk_i) disable iff (soft_rst)
    fn_r[0] == 4'h0 ##1 !soft_rst |-> pin_o[0] == $past(out_inv_r[0]))
    else $error("off code did not drive low level");
  a_reg_pin_level: assert property (@(posedge clk_i) disable iff (soft_rst)
    fn_r[1] == 4'h2 ##1 !soft_rst |-> pin_o[1] == ($past(out_lvl_r[1]) ^ $past(out_inv_r[1])))
    else $error("register level not driven on pin");
  a_phase_hold: assert property (@(posedge clk_i) disable iff (soft_rst)
    ($past(op_state_code_i) == boot_gpio_pkg::OP_PLAY && !$past(soft_rst)) |-> $stable(ramp_phase_o))
    else $error("ramp phase changed during play");

endmodule : boot_gpio_mux_status_regs

/* verification/boot_gpio_mux_status_regs_tb.sv */
// Self-checking testbench for the boot, pin multiplexer and status register bank
`timescale 1ns/1ps
module boot_gpio_mux_status_regs_tb;
  logic clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, memory_din_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, rd;
  logic [1:0] htrans_i = 0, op_state_code_i = 0;
  logic [2:0] hsize_i = 3'h2, pin_i = 3'h7, pin_o, pin_oe_o;
  logic [7:0] stage_supply_code_i = 8'hdf, coef_byte_o;
  logic left_muted_flag_i = 1, right_muted_flag_i = 0, clock_invalid_i = 1, warning_out_n_i = 0;
  logic fault_out_n_i = 1, two_level_wave_i = 1, multi_level_wave_i = 0;
  logic hreadyout_o, hresp_o, memory_clk_o, memory_dout_o, memory_select_n_o, coef_valid_o;
  logic coef_from_memory_o, biquad_first_word_o, hiz_request_o, pin_reset_o, phase_sync_o;
  logic [1:0] ramp_phase_o;
  logic [31:0] hrdata_o;
  int fail_count = 0, checks = 0, cyc = 0;
  int toggles = 0, low_cycles = 0, coefs = 0;
  logic mclk_q = 1'b0;
  logic [7:0] ri [9] = '{8'h57, 8'h58, 8'h5a, 8'h5b, 8'h5c, 8'h60, 8'h64, 8'h67, 8'h6a};
  logic [7:0] re [9] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};
  logic [7:0] wi [8] = '{8'h57, 8'h58, 8'h59, 8'h5a, 8'h5c, 8'h60, 8'h65, 8'h66};
  logic [7:0] wv [8] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h01, 8'h05, 8'h05, 8'h02};
  logic [15:0] fn_exp = 16'h0856;
  boot_gpio_mux_status_regs #(.BOOT_BYTES(2), .SILICON_ID(8'h5a)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .memory_din_i(memory_din_i),
    .memory_clk_o(memory_clk_o), .memory_dout_o(memory_dout_o), .memory_select_n_o(memory_select_n_o),
    .coef_byte_o(coef_byte_o), .coef_valid_o(coef_valid_o), .coef_from_memory_o(coef_from_memory_o),
    .biquad_first_word_o(biquad_first_word_o), .stage_supply_code_i(stage_supply_code_i),
    .op_state_code_i(op_state_code_i), .left_muted_flag_i(left_muted_flag_i),
    .right_muted_flag_i(right_muted_flag_i), .clock_invalid_i(clock_invalid_i),
    .warning_out_n_i(warning_out_n_i), .fault_out_n_i(fault_out_n_i), .two_level_wave_i(two_level_wave_i),
    .multi_level_wave_i(multi_level_wave_i), .hiz_request_o(hiz_request_o), .pin_reset_o(pin_reset_o),
    .phase_sync_o(phase_sync_o), .ramp_phase_o(ramp_phase_o));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  // Serial memory frame monitor
  always @(posedge clk_i) begin
    mclk_q <= memory_clk_o;
    if (!memory_select_n_o) begin
      low_cycles <= low_cycles + 1;
      if (memory_clk_o !== mclk_q) toggles <= toggles + 1;
    end
    if (coef_valid_o === 1'b1) coefs <= coefs + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {22'h0, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    cmp("response", 32'h0, {31'h0, hresp_o});
  endtask : xfer
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, {24'h0, v});
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 32'h0);
    cmp("register", {24'h0, e}, rd);
  endtask : rdc
  task automatic boot_run(input logic [7:0] ctrl, input logic [7:0] e, input int bits, input int half);
    int t0, l0, c0;
    t0 = toggles;
    l0 = low_cycles;
    c0 = coefs;
    wr(8'h56, ctrl);
    wr(8'h56, ctrl | 8'h01);
    rdc(8'h5b, 8'h00);
    for (int k = 0; k < 400 && rd[0] !== 1'b1; k++) xfer(1'b0, 8'h5b, 32'h0);
    rdc(8'h5b, e);
    cmp("select", 32'h1, {31'h0, memory_select_n_o});
    cmp("clock toggles", 2 * bits, toggles - t0);
    cmp("frame cycles", 2 * bits * half, low_cycles - l0);
    cmp("idle clock", {31'h0, ctrl[2]}, {31'h0, memory_clk_o});
    cmp("coef count", 32'd2, coefs - c0);
    cmp("coef byte", {24'h0, {8{memory_din_i}}}, {24'h0, coef_byte_o});
  endtask : boot_run
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 9; i++) rdc(ri[i], re[i]);
    for (int i = 0; i < 8; i++) wr(wi[i], wv[i]);
    for (int i = 0; i < 8; i++) rdc(wi[i], wv[i]);
    cmp("marker", 32'h1, {31'h0, biquad_first_word_o});
    cmp("dir", 32'h5, {29'h0, pin_oe_o});
    wr(8'h67, 8'hff);
    rdc(8'h67, 8'h5a);
    wr(8'h5e, 8'h11);
    rdc(8'h5e, 8'hdf);
    rdc(8'h10, 8'h00);
    op_state_code_i <= 2'h2;
    rdc(8'h68, 8'h02);
    rdc(8'h69, 8'h01);
    wr(8'h60, 8'h07);
    wr(8'h66, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'h61, c[7:0]);
      repeat (2) @(posedge clk_i);
      cmp("pin0", {31'h0, fn_exp[c]}, {31'h0, pin_o[0]});
    end
    wr(8'h61, 8'h02);
    wr(8'h66, 8'h01);
    repeat (2) @(posedge clk_i);
    cmp("pin0 inverted", 32'h0, {31'h0, pin_o[0]});
    right_muted_flag_i <= 1'b1;
    wr(8'h61, 8'h03);
    repeat (2) @(posedge clk_i);
    cmp("both muted", 32'h0, {31'h0, pin_o[0]});
    wr(8'h66, 8'h00);
    wr(8'h64, 8'h2d);
    pin_i <= 3'h6;
    repeat (4) @(posedge clk_i);
    cmp("hiz", 32'h1, {31'h0, hiz_request_o});
    cmp("sync", 32'h1, {31'h0, phase_sync_o});
    pin_i <= 3'h3;
    repeat (4) @(posedge clk_i);
    cmp("pin reset", 32'h1, {31'h0, pin_reset_o});
    pin_i <= 3'h7;
    repeat (4) @(posedge clk_i);
    rdc(8'h57, 8'h03);
    rdc(8'h64, 8'h0c);
    op_state_code_i <= 2'h0;
    wr(8'h6a, 8'h0c);
    repeat (3) @(posedge clk_i);
    cmp("phase", 32'h3, {30'h0, ramp_phase_o});
    op_state_code_i <= 2'h3;
    wr(8'h6a, 8'h04);
    repeat (3) @(posedge clk_i);
    cmp("phase in play", 32'h3, {30'h0, ramp_phase_o});
    rdc(8'h6a, 8'h04);
    boot_run(8'h18, 8'h01, 48, 2);
    cmp("source", 32'h1, {31'h0, coef_from_memory_o});
    memory_din_i <= 1'b1;
    boot_run(8'h36, 8'h03, 56, 3);
    end_sim();
  end
endmodule : boot_gpio_mux_status_regs_tb
